// ### rtl/ccfd_chan_cfg.sv
// one stored configuration frame of a single channel
`timescale 1ns/1ns
`include "ccfd_map.svh"
module ccfd_chan_cfg #(
    parameter int W = `CCFD_HI_BIT + 1,
    parameter logic [W-1:0] KEEP = `CCFD_KEEP_ALL
) (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // write side
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    // stored frame
    output logic [W-1:0] cfg
);
    // bits outside KEEP stay low, so fixed-pattern bits read back as zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg <= `CCFD_STORE_RESET;
        end else if (ce && wr_en) begin
            cfg <= wr_data & KEEP;
        end
    end
endmodule

// ### rtl/ccfd_link_rx.sv
// serial link end: shifts frames in on the link clock and answers on miso
`timescale 1ns/1ns
`include "ccfd_map.svh"
module ccfd_link_rx (
    // link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    // system reset
    input wire logic sys_rst,
    // towards the core domain
    output logic [`CCFD_FRAME_BITS-1:0] rx_word,
    output logic frame_tgl,
    input wire logic [`CCFD_FRAME_BITS-1:0] resp_word
);
    logic [`CCFD_CNT_W-1:0] bit_cnt; // falling edges seen in this frame
    logic [`CCFD_FRAME_BITS-1:0] tx_shift; // answer bits still to send

    // bit counter, cleared whenever the frame select is released
    always_ff @(negedge sclk or posedge sys_rst or posedge cs_n) begin
        if (sys_rst || cs_n) begin
            bit_cnt <= '0;
        end else if (bit_cnt != `CCFD_CNT_W'(`CCFD_FRAME_BITS)) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // receive shift, msb first; bits beyond the 32nd are dropped
    always_ff @(negedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_word <= '0;
        end else if (!cs_n && bit_cnt != `CCFD_CNT_W'(`CCFD_FRAME_BITS)) begin
            rx_word <= {rx_word[`CCFD_FRAME_BITS-2:0], mosi};
        end
    end

    // event to the core: toggles as the last frame bit is taken
    always_ff @(negedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_tgl <= 1'b0;
        end else if (!cs_n && bit_cnt == `CCFD_CNT_W'(`CCFD_FRAME_BITS - 1)) begin
            frame_tgl <= ~frame_tgl;
        end
    end

    // answer out on rising edges; the answer word changes only between frames
    always_ff @(posedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_shift <= '0;
            miso <= 1'b0;
        end else if (bit_cnt == '0) begin
            miso <= resp_word[`CCFD_FRAME_BITS-1];
            tx_shift <= {resp_word[`CCFD_FRAME_BITS-2:0], 1'b0};
        end else begin
            miso <= tx_shift[`CCFD_FRAME_BITS-1];
            tx_shift <= {tx_shift[`CCFD_FRAME_BITS-2:0], 1'b0};
        end
    end
endmodule

// ### rtl/ccfd_map.svh
// field positions, command codes, masks and timing constants of the channel frame decoder
`ifndef CCFD_MAP_SVH
`define CCFD_MAP_SVH
// frame geometry
`define CCFD_FRAME_BITS 32
`define CCFD_CNT_W 6
`define CCFD_CMD_MSB 31
`define CCFD_CMD_LSB 28
`define CCFD_RW_BIT 27
`define CCFD_HI_BIT 26
`define CCFD_LO_BIT 25
`define CCFD_FIX_BIT 24
`define CCFD_TDIAG_MSB 23
`define CCFD_TDIAG_LSB 22
`define CCFD_RDSEL_BIT 21
`define CCFD_THR_MSB 20
`define CCFD_THR_LSB 15
`define CCFD_TCOMP_MSB 14
`define CCFD_TCOMP_LSB 13
`define CCFD_SCOMP_BIT 12
`define CCFD_BLANK_MSB 11
`define CCFD_BLANK_LSB 9
`define CCFD_REENG_BIT 8
`define CCFD_SENSE_BIT 7
`define CCFD_OLC_BIT 6
`define CCFD_GCC_MSB 5
`define CCFD_GCC_LSB 4
`define CCFD_POL_BIT 3
`define CCFD_SIDE_BIT 2
`define CCFD_EN_BIT 1
`define CCFD_PAR_BIT 0
// command codes
`define CCFD_CMD_CH6 4'h6
`define CCFD_CMD_CH7 4'h7
`define CCFD_CMD_CH8 4'h8
// stored bits [26:0]; bit 0 never stored, bit 24 forced low for frames six and seven
`define CCFD_KEEP_FIX0 27'h6fffffe
`define CCFD_KEEP_ALL 27'h7fffffe
`define CCFD_STORE_RESET 27'h0000000
// timing
`define CCFD_CLK_MHZ 25
`define CCFD_NS_PER_US 1000
`define CCFD_CYC_W 12
`define CCFD_CYC(ns) ((((ns) * `CCFD_CLK_MHZ) + `CCFD_NS_PER_US - 1) / `CCFD_NS_PER_US)
`define CCFD_OFF0_NS 31000
`define CCFD_OFF1_NS 48000
`define CCFD_OFF2_NS 62500
`define CCFD_OFF3_NS 125000
`define CCFD_DIAG0_NS 25600
`define CCFD_DIAG1_NS 61200
`define CCFD_DIAG2_NS 105600
`define CCFD_DIAG3_NS 150000
`define CCFD_BLK0_NS 11100
`define CCFD_BLK1_NS 15600
`define CCFD_BLK2_NS 20000
`define CCFD_BLK3_NS 31100
`define CCFD_BLK4_NS 42200
`define CCFD_BLK5_NS 53300
`define CCFD_BLK6_NS 97800
`define CCFD_BLK7_NS 142200
`endif

// ### rtl/ccfd_pkg.sv
// types shared by the channel frame decoder
package ccfd_pkg;
    // frame handling sequence, gray coded along the path
    typedef enum logic [1:0] {
        CCFD_IDLE = 2'b00,
        CCFD_CHECK = 2'b01,
        CCFD_APPLY = 2'b11,
        CCFD_ANSWER = 2'b10
    } ccfd_state_t;
endpackage

// ### rtl/ccfd_top.sv
// channel six to eight configuration frame decoder with second bridge settings
`timescale 1ns/1ns
`include "ccfd_map.svh"
module ccfd_top #(
    parameter int CYC_W = `CCFD_CYC_W
) (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    // neighbouring logic on clk
    input wire logic bridge_b_timer_sharing,
    input wire logic [2:0][5:0] actual_threshold,
    // per-channel fields, index 0 is channel six
    output logic [2:0] channel_enable,
    output logic [2:0] driver_side_select,
    output logic [2:0] transistor_p_channel,
    output logic [2:0][1:0] gate_current_select,
    output logic [2:0] open_load_current_high,
    output logic [2:0] current_sense_method,
    output logic [2:0][2:0] overcurrent_blanking_time,
    output logic [2:0] threshold_supply_comp,
    output logic [2:0][1:0] threshold_temperature_comp,
    output logic [2:0][5:0] overcurrent_threshold_code,
    output logic [2:0] threshold_readback_select,
    // per-channel derived controls
    output logic [2:0] reengage_policy,
    output logic [2:0] blank_gates_detection,
    output logic [2:0][CYC_W-1:0] blanking_cycles,
    output logic [2:0] own_diag_timer_used,
    output logic [2:0][CYC_W-1:0] diag_time_cycles,
    // second bridge
    output logic bridge_b_group_enable,
    output logic [CYC_W-1:0] bridge_b_limit_off_time,
    output logic bridge_b_current_limit_on,
    output logic bridge_b_active_freewheel,
    output logic peak_hold_b_enable,
    // frame status
    output logic frame_done,
    output logic parity_error
);
    localparam int SW = `CCFD_HI_BIT + 1; // stored frame width
    localparam int FB = `CCFD_FRAME_BITS;
    // cycle counts, least times rounded up
    localparam logic [CYC_W-1:0] OFF0_CYC = CYC_W'(`CCFD_CYC(`CCFD_OFF0_NS));
    localparam logic [CYC_W-1:0] OFF1_CYC = CYC_W'(`CCFD_CYC(`CCFD_OFF1_NS));
    localparam logic [CYC_W-1:0] OFF2_CYC = CYC_W'(`CCFD_CYC(`CCFD_OFF2_NS));
    localparam logic [CYC_W-1:0] OFF3_CYC = CYC_W'(`CCFD_CYC(`CCFD_OFF3_NS));
    localparam logic [CYC_W-1:0] DIAG0_CYC = CYC_W'(`CCFD_CYC(`CCFD_DIAG0_NS));
    localparam logic [CYC_W-1:0] DIAG1_CYC = CYC_W'(`CCFD_CYC(`CCFD_DIAG1_NS));
    localparam logic [CYC_W-1:0] DIAG2_CYC = CYC_W'(`CCFD_CYC(`CCFD_DIAG2_NS));
    localparam logic [CYC_W-1:0] DIAG3_CYC = CYC_W'(`CCFD_CYC(`CCFD_DIAG3_NS));
    localparam logic [CYC_W-1:0] BLK0_CYC = CYC_W'(`CCFD_CYC(`CCFD_BLK0_NS));
    localparam logic [CYC_W-1:0] BLK1_CYC = CYC_W'(`CCFD_CYC(`CCFD_BLK1_NS));
    localparam logic [CYC_W-1:0] BLK2_CYC = CYC_W'(`CCFD_CYC(`CCFD_BLK2_NS));
    localparam logic [CYC_W-1:0] BLK3_CYC = CYC_W'(`CCFD_CYC(`CCFD_BLK3_NS));
    localparam logic [CYC_W-1:0] BLK4_CYC = CYC_W'(`CCFD_CYC(`CCFD_BLK4_NS));
    localparam logic [CYC_W-1:0] BLK5_CYC = CYC_W'(`CCFD_CYC(`CCFD_BLK5_NS));
    localparam logic [CYC_W-1:0] BLK6_CYC = CYC_W'(`CCFD_CYC(`CCFD_BLK6_NS));
    localparam logic [CYC_W-1:0] BLK7_CYC = CYC_W'(`CCFD_CYC(`CCFD_BLK7_NS));

    logic [FB-1:0] rx_word; // link shift register, static between frames
    logic frame_tgl; // link-side frame event
    logic tgl_s1, tgl_s2, tgl_s3; // event synchroniser and edge history
    logic frame_pulse; // one enabled clk cycle per received frame
    logic [FB-1:0] frame_q; // frame under decode
    logic [FB-1:0] resp_word; // answer for the next frame
    ccfd_pkg::ccfd_state_t state; // frame handling state
    ccfd_pkg::ccfd_state_t next_state;
    logic [2:0] sel_hit; // decoded frame, one-hot by channel
    logic parity_ok; // whole frame holds an odd count of ones
    logic write_ok; // frame may change stored state
    logic [2:0] wr_stb; // store strobes to the channel registers
    logic [2:0][SW-1:0] cfg_frame; // stored frames
    logic [SW-1:0] rd_cfg; // frame selected for readback
    logic [FB-2:0] rsp_body; // answer without its parity bit

    // link end, clocked by the host's serial clock
    ccfd_link_rx u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .mosi(mosi),
        .miso(miso),
        .sys_rst(sys_rst),
        .rx_word(rx_word),
        .frame_tgl(frame_tgl),
        .resp_word(resp_word)
    );

    // the toggle crosses through two flops; the second and a third history flop feed the edge detector
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
        end else if (ce) begin
            tgl_s1 <= frame_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end
    assign frame_pulse = tgl_s2 ^ tgl_s3;

    // command decode of the held frame
    always_comb begin
        case (frame_q[`CCFD_CMD_MSB:`CCFD_CMD_LSB])
            `CCFD_CMD_CH6: sel_hit = 3'b001;
            `CCFD_CMD_CH7: sel_hit = 3'b010;
            `CCFD_CMD_CH8: sel_hit = 3'b100;
            default: sel_hit = 3'b000;
        endcase
    end

    // odd parity, so total ones is odd
    assign parity_ok = ^frame_q;
    assign write_ok = parity_ok && (|sel_hit) && !frame_q[`CCFD_RW_BIT];
    assign wr_stb = (state == ccfd_pkg::CCFD_APPLY && write_ok) ? sel_hit : 3'b000;

    // next state: take, check, store, answer
    always_comb begin
        case (state)
            ccfd_pkg::CCFD_IDLE: next_state = frame_pulse ? ccfd_pkg::CCFD_CHECK : state;
            ccfd_pkg::CCFD_CHECK: next_state = ccfd_pkg::CCFD_APPLY;
            ccfd_pkg::CCFD_APPLY: next_state = ccfd_pkg::CCFD_ANSWER;
            ccfd_pkg::CCFD_ANSWER: next_state = ccfd_pkg::CCFD_IDLE;
            default: next_state = ccfd_pkg::CCFD_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ccfd_pkg::CCFD_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // frame capture; the link word holds still until the next frame starts
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_q <= '0;
        end else if (ce && state == ccfd_pkg::CCFD_IDLE && frame_pulse) begin
            frame_q <= rx_word;
        end
    end

    // channel registers; frames six and seven keep bit 24 at zero
    ccfd_chan_cfg #(.W(SW), .KEEP(`CCFD_KEEP_FIX0)) u_ch6 (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .wr_en(wr_stb[0]),
        .wr_data(frame_q[SW-1:0]),
        .cfg(cfg_frame[0])
    );
    ccfd_chan_cfg #(.W(SW), .KEEP(`CCFD_KEEP_FIX0)) u_ch7 (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .wr_en(wr_stb[1]),
        .wr_data(frame_q[SW-1:0]),
        .cfg(cfg_frame[1])
    );
    ccfd_chan_cfg #(.W(SW), .KEEP(`CCFD_KEEP_ALL)) u_ch8 (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .wr_en(wr_stb[2]),
        .wr_data(frame_q[SW-1:0]),
        .cfg(cfg_frame[2])
    );

    // readback source, with the threshold swapped when the actual one is asked for
    always_comb begin
        rd_cfg = '0;
        for (int i = 0; i < 3; i++) begin
            if (sel_hit[i] && parity_ok) begin
                rd_cfg = cfg_frame[i];
                if (cfg_frame[i][`CCFD_RDSEL_BIT]) begin
                    rd_cfg[`CCFD_THR_MSB:`CCFD_THR_LSB] = actual_threshold[i];
                end
            end
        end
        rsp_body = {frame_q[`CCFD_CMD_MSB:`CCFD_RW_BIT], rd_cfg[SW-1:1]};
    end

    // answer word and frame status; a bad frame answers with an empty body
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp_word <= '0;
            frame_done <= 1'b0;
            parity_error <= 1'b0;
        end else if (ce) begin
            frame_done <= (state == ccfd_pkg::CCFD_ANSWER);
            parity_error <= (state == ccfd_pkg::CCFD_ANSWER) && !parity_ok;
            if (state == ccfd_pkg::CCFD_ANSWER) begin
                resp_word <= {rsp_body, ~^rsp_body};
            end
        end
    end

    // raw fields straight from the stored frames
    for (genvar g = 0; g < 3; g++) begin : g_field
        assign channel_enable[g] = cfg_frame[g][`CCFD_EN_BIT];
        assign driver_side_select[g] = cfg_frame[g][`CCFD_SIDE_BIT];
        assign transistor_p_channel[g] = cfg_frame[g][`CCFD_POL_BIT];
        assign gate_current_select[g] = cfg_frame[g][`CCFD_GCC_MSB:`CCFD_GCC_LSB];
        assign open_load_current_high[g] = cfg_frame[g][`CCFD_OLC_BIT];
        assign current_sense_method[g] = cfg_frame[g][`CCFD_SENSE_BIT];
        assign overcurrent_blanking_time[g] = cfg_frame[g][`CCFD_BLANK_MSB:`CCFD_BLANK_LSB];
        assign threshold_supply_comp[g] = cfg_frame[g][`CCFD_SCOMP_BIT];
        assign threshold_temperature_comp[g] = cfg_frame[g][`CCFD_TCOMP_MSB:`CCFD_TCOMP_LSB];
        assign overcurrent_threshold_code[g] = cfg_frame[g][`CCFD_THR_MSB:`CCFD_THR_LSB];
        assign threshold_readback_select[g] = cfg_frame[g][`CCFD_RDSEL_BIT];
    end
    assign bridge_b_group_enable = cfg_frame[2][`CCFD_HI_BIT];
    assign peak_hold_b_enable = cfg_frame[2][`CCFD_FIX_BIT];
    // active freewheel bit of frame seven
    assign bridge_b_active_freewheel = cfg_frame[1][`CCFD_LO_BIT];

    // off-state diagnostic code to cycles
    function automatic logic [CYC_W-1:0] diag_cyc(input logic [1:0] code);
        case (code)
            2'h0: diag_cyc = DIAG0_CYC;
            2'h1: diag_cyc = DIAG1_CYC;
            2'h2: diag_cyc = DIAG2_CYC;
            default: diag_cyc = DIAG3_CYC;
        endcase
    endfunction

    // blanking code to cycles
    function automatic logic [CYC_W-1:0] blank_cyc(input logic [2:0] code);
        case (code)
            3'h0: blank_cyc = BLK0_CYC;
            3'h1: blank_cyc = BLK1_CYC;
            3'h2: blank_cyc = BLK2_CYC;
            3'h3: blank_cyc = BLK3_CYC;
            3'h4: blank_cyc = BLK4_CYC;
            3'h5: blank_cyc = BLK5_CYC;
            3'h6: blank_cyc = BLK6_CYC;
            default: blank_cyc = BLK7_CYC;
        endcase
    endfunction

    // diagnostic timer selection; shared bridge timing overrides the channel's own
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            own_diag_timer_used <= 3'h7;
            diag_time_cycles <= '0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                diag_time_cycles[i] <= diag_cyc(cfg_frame[i][`CCFD_TDIAG_MSB:`CCFD_TDIAG_LSB]);
                own_diag_timer_used[i] <= !(bridge_b_group_enable && !bridge_b_timer_sharing);
            end
        end
    end

    // blanking: gates detection only with drain-source sensing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            blank_gates_detection <= 3'h7;
            blanking_cycles <= '0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                blanking_cycles[i] <= blank_cyc(cfg_frame[i][`CCFD_BLANK_MSB:`CCFD_BLANK_LSB]);
                // shunt mode only delays the report
                blank_gates_detection[i] <= !cfg_frame[i][`CCFD_SENSE_BIT];
            end
        end
    end

    // re-engagement; bridge members always wait for a readout, since the host
    // must clear the latches before the bridge may run again
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reengage_policy <= 3'h0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                reengage_policy[i] <= bridge_b_group_enable || cfg_frame[i][`CCFD_REENG_BIT];
            end
        end
    end

    // second bridge off-time and current limit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bridge_b_limit_off_time <= OFF0_CYC;
            bridge_b_current_limit_on <= 1'b0;
        end else if (ce) begin
            case (cfg_frame[0][`CCFD_HI_BIT:`CCFD_LO_BIT])
                2'h0: bridge_b_limit_off_time <= OFF0_CYC;
                2'h1: bridge_b_limit_off_time <= OFF1_CYC;
                2'h2: bridge_b_limit_off_time <= OFF2_CYC;
                default: bridge_b_limit_off_time <= OFF3_CYC;
            endcase
            // limit only with shunt sensing on channel seven
            bridge_b_current_limit_on <= cfg_frame[1][`CCFD_HI_BIT] &&
                cfg_frame[1][`CCFD_SENSE_BIT];
        end
    end

    // checks
    sequence s_take;
        state == ccfd_pkg::CCFD_IDLE && frame_pulse && ce;
    endsequence
    sequence s_run;
        ce [*3];
    endsequence

    a_frame_answer: assert property (
        @(posedge clk) disable iff (sys_rst) s_take ##1 s_run |=> frame_done)
        else $error("frame not answered three cycles after capture");
    a_parity_gate: assert property (
        @(posedge clk) disable iff (sys_rst) (|wr_stb) |-> (^frame_q) && !frame_q[`CCFD_RW_BIT])
        else $error("store without good parity or with read bit");
    a_cmd_route: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_stb[1] |-> frame_q[`CCFD_CMD_MSB:`CCFD_CMD_LSB] == `CCFD_CMD_CH7)
        else $error("channel seven stored by another command");
    a_read_keeps: assert property (
        @(posedge clk) disable iff (sys_rst)
        (state == ccfd_pkg::CCFD_APPLY && frame_q[`CCFD_RW_BIT]) |=> $stable(cfg_frame))
        else $error("read-only frame changed stored state");
    a_reengage_forced: assert property (
        @(posedge clk) disable iff (sys_rst) (ce && bridge_b_group_enable) |=> &reengage_policy)
        else $error("bridge channel allowed plain re-engagement");
    a_timer_ignored: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && bridge_b_group_enable && !bridge_b_timer_sharing) |=> own_diag_timer_used == 3'h0)
        else $error("own diagnostic timer used while shared");
    a_limit_shunt: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && !cfg_frame[1][`CCFD_SENSE_BIT]) |=> !bridge_b_current_limit_on)
        else $error("current limit active without shunt sensing");
    a_off_time_map: assert property (
        @(posedge clk) disable iff (sys_rst)
        (ce && cfg_frame[0][`CCFD_HI_BIT:`CCFD_LO_BIT] == 2'h3) |=>
        bridge_b_limit_off_time == OFF3_CYC)
        else $error("longest off-time code gave wrong count");
    a_blank_gating: assert property (
        @(posedge clk) disable iff (sys_rst)
        ce |=> blank_gates_detection == ~$past(current_sense_method))
        else $error("blanking gate does not follow sensing method");
endmodule

// ### sim/ccfd_host.sv
// serial master model that shifts whole frames into the decoder
`timescale 1ns/1ns
module ccfd_host (
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    // clock rests low and select high between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // host duty: latch clearing frames lie outside this block
    task automatic xfer(input logic [31:0] w, output logic [31:0] r);
        cs_n = 1'b0;
        #7;
        for (int i = 31; i >= 0; i--) begin
            mosi = w[i];
            sclk = 1'b1;
            #6;
            r[i] = miso;
            sclk = 1'b0;
            #6;
        end
        cs_n = 1'b1;
        // released line flips so a stale bit cannot pass for data
        mosi = ~mosi;
    endtask
endmodule

// ### sim/tb_top.sv
// self-checking bench of the channel frame decoder
`timescale 1ns/1ns
`define CHK(a, e) begin \
    check_count++; \
    if ((a) !== (e)) begin \
        fails++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, a, e); \
    end \
end
module tb_top;
    logic clk = 0, sys_rst = 0, share = 1, sclk, cs_n, mosi, miso, done, perr, lim, grp;
    logic ce = 1, afw, ph;
    logic [2:0] own, rp, en, side, pch, olc, csm, scomp, rds, bgd;
    logic [2:0][1:0] gcs, tcomp;
    logic [2:0][2:0] obt;
    logic [2:0][5:0] act = '0, thr;
    logic [2:0][11:0] blk, dgt;
    logic [11:0] toff;
    logic [31:0] ans;
    int fails = 0, check_count = 0, frz = 0;
    // expected cycle counts at 25 MHz
    logic [11:0] bt [8] = '{12'h116, 12'h186, 12'h1f4, 12'h30a,
        12'h41f, 12'h535, 12'h98d, 12'hde3};
    logic [11:0] dt [4] = '{12'h280, 12'h5fa, 12'ha50, 12'hea6};
    logic [11:0] ot [4] = '{12'h307, 12'h4b0, 12'h61b, 12'hc35};
    always #20 clk = ~clk;
    ccfd_host u_ccfd_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    ccfd_top u_ccfd_top (.clk(clk), .sys_rst(sys_rst), .ce(ce), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .miso(miso), .bridge_b_timer_sharing(share), .actual_threshold(act),
        .channel_enable(en), .driver_side_select(side), .transistor_p_channel(pch),
        .gate_current_select(gcs), .open_load_current_high(olc), .current_sense_method(csm),
        .overcurrent_blanking_time(obt), .threshold_supply_comp(scomp),
        .threshold_temperature_comp(tcomp), .overcurrent_threshold_code(thr),
        .threshold_readback_select(rds), .reengage_policy(rp),
        .blank_gates_detection(bgd), .blanking_cycles(blk), .own_diag_timer_used(own),
        .diag_time_cycles(dgt), .bridge_b_group_enable(grp), .bridge_b_limit_off_time(toff),
        .bridge_b_current_limit_on(lim), .bridge_b_active_freewheel(afw),
        .peak_hold_b_enable(ph), .frame_done(done), .parity_error(perr));
    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one frame with odd parity, optionally spoiled; waits for the event
    task automatic send(input logic [3:0] c, input logic rw, input logic [26:1] b,
        input logic bad);
        logic [31:0] w;
        int n;
        w = {c, rw, b, 1'b0};
        w[0] = ~^w[31:1] ^ bad;
        u_ccfd_host.xfer(w, ans);
        // a held enable keeps the frame waiting in the synchroniser
        repeat (frz) @(negedge clk);
        ce = 1'b1;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) begin
            fails++;
            report_and_stop();
        end
        `CHK(perr, bad)
        repeat (12) @(negedge clk);
    endtask
    initial begin
        // a real edge, so the link-side flops reset before any frame
        #1 sys_rst = 1'b1;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        `CHK(own, 3'h7)
        `CHK(toff, ot[0])
        // every off-time code, fixed bit written high
        for (int k = 0; k < 4; k++) begin
            send(4'h6, 1'b0, {k[1:0], 1'b1, 23'h0}, 1'b0);
            `CHK(toff, ot[k])
            if (k > 0) `CHK(ans[24], 1'b0)
        end
        // every blanking and diagnostic code, limit only with shunt
        for (int k = 0; k < 8; k++) begin
            send(4'h7, 1'b0, {1'b1, k[0], 1'b0, k[1:0], 7'h0, 3'h0, k[2:0], k[1], k[0], 6'h0},
                1'b0);
            `CHK(blk[1], bt[k])
            `CHK(dgt[1], dt[k[1:0]])
            `CHK(lim, k[0])
            `CHK(afw, k[0])
            `CHK(rp[1], k[1])
            `CHK(bgd[1], !k[0])
        end
        // read-only and bad-parity frames store nothing
        send(4'h7, 1'b1, 26'h0, 1'b0);
        `CHK(blk[1], bt[7])
        send(4'h7, 1'b0, 26'h0, 1'b1);
        `CHK(blk[1], bt[7])
        `CHK(ans[11:9], 3'h7)
        // grouping forces policy and shared timers
        share = 1'b0;
        send(4'h8, 1'b0, {1'b1, 25'h0}, 1'b0);
        `CHK(grp, 1'b1)
        `CHK(own, 3'h0)
        `CHK(rp, 3'h7)
        // the refused frame answers with an empty body and its own parity
        `CHK(ans[26:1], 26'h0)
        `CHK(^ans, 1'b1)
        // an unknown command stores nothing
        send(4'h9, 1'b0, 26'h3ffffff, 1'b0);
        `CHK(blk[1], bt[7])
        `CHK(grp, 1'b1)
        // actual threshold returned when selected
        act[0] = 6'h2a;
        send(4'h6, 1'b0, {6'h1, 6'h15, 14'h0}, 1'b0);
        `CHK(thr[0], 6'h15)
        `CHK(ans[31:28], 4'h9)
        `CHK(ans[26:1], 26'h0)
        send(4'h6, 1'b1, 26'h0, 1'b0);
        `CHK(ans[20:15], 6'h2a)
        // every raw field of frame eight lands on its own output
        send(4'h8, 1'b0, {3'h7, 2'h2, 1'b1, 6'h2c, 2'h2, 1'b1, 3'h5, 3'h7, 2'h2, 3'h7}, 1'b0);
        `CHK(en[2], 1'b1)
        `CHK(side[2], 1'b1)
        `CHK(pch[2], 1'b1)
        `CHK(gcs[2], 2'h2)
        `CHK(olc[2], 1'b1)
        `CHK(csm[2], 1'b1)
        `CHK(obt[2], 3'h5)
        `CHK(blk[2], bt[5])
        `CHK(bgd[2], 1'b0)
        `CHK(scomp[2], 1'b1)
        `CHK(tcomp[2], 2'h2)
        `CHK(thr[2], 6'h2c)
        `CHK(rds[2], 1'b1)
        `CHK(dgt[2], dt[2])
        `CHK(ph, 1'b1)
        // a frozen core holds the taken frame until the enable returns
        ce = 1'b0;
        frz = 20;
        send(4'h6, 1'b0, {6'h0, 6'h2b, 14'h0}, 1'b0);
        frz = 0;
        `CHK(thr[0], 6'h2b)
        report_and_stop();
    end
endmodule
